// *** fsps_pkg.sv ***
package fsps_pkg;
  // control/status register layout
  localparam logic [7:0] CSR_ADDR = 8'h00;
  localparam logic [7:0] PTRL_ADDR = 8'h01;
  localparam logic [7:0] PTRH_ADDR = 8'h02;
  localparam logic [7:0] DATL_ADDR = 8'h03;
  localparam logic [7:0] DATH_ADDR = 8'h04;
  localparam logic [7:0] CFG_ADDR = 8'h05;
  localparam int CSR_EN_BIT = 0;
  localparam int CSR_ERASE_BIT = 1;
  localparam int CSR_WRITE_BIT = 2;
  localparam int CSR_BUSY_BIT = 6;
  localparam int CSR_IE_BIT = 7;
  localparam int CSR_REEN_BIT = 4;
  localparam int CSR_LOCK_BIT = 3;
  localparam int CFG_IE_BIT = 0;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_LOAD = 7'h01;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_LOCK = 7'h09;
  localparam logic [2:0] ARM_WINDOW = 3'h4;
  localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
  localparam int OP_TIME_US = 4;
  localparam int CLK_MHZ = 50;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    FSPS_IDLE = 2'b00,
    FSPS_ARMED = 2'b01,
    FSPS_BUSY = 2'b10
  } fsps_state_t;
endpackage : fsps_pkg

// *** fsps_page_buf.sv ***
`timescale 1ns/1ns
module fsps_page_buf
  import fsps_pkg::*;
#(
  parameter int WORDS = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // control
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [AW-1:0] load_addr_i,
  input wire logic [15:0] load_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  // contents
  output logic [15:0] rd_data_o,
  output logic [WORDS-1:0] loaded_o
);
  logic [15:0] mem [WORDS];

  always_ff @(posedge sys_clk_i) begin
    if (load_i) begin
      mem[load_addr_i] <= load_data_i; // RULE9
    end
  end

  // cleared words read as erased flash
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || clear_i) begin
      loaded_o <= '0; // RULE15
    end else if (load_i) begin
      loaded_o[load_addr_i] <= 1'b1;
    end
  end

  always_comb begin
    rd_data_o = loaded_o[rd_addr_i] ? mem[rd_addr_i] : 16'hffff;
  end
endmodule : fsps_page_buf

// *** fsps_seq.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: unprogrammed boot select fuse starts at 0x0000, programmed starts at boot loader.
// RULE2: fuses are input pins only; software cannot change them.
// RULE3: 16-bit pointer: high byte gives bits 15..8, low byte bits 7..0.
// RULE4: word address splits into word-in-page low bits and page high bits.
// RULE5: target address latched when an operation starts.
// RULE6: lock-bit setting ignores the pointer entirely.
// RULE7: load-program reads flash bytewise, byte select bit picks low or high byte.
// RULE8: software erases a page before writing it from the buffer.
// RULE9: buffer words may be loaded in any order.
// RULE10: software uses the same page for erase and following write.
// RULE11: erase command then store-program within four cycles; page field only used.
// RULE12: erase of app region keeps boot region readable; else halt cpu.
// RULE13: load command then store-program within four cycles loads the data pair.
// RULE14: buffer word chosen by pointer bits 5..1.
// RULE15: buffer cleared after page write, on read re-enable, and on reset.
// RULE16: software never loads one buffer word twice without clearing.
// RULE17: eeprom write during buffer loading discards loaded data.
// RULE18: write command then store-program within four cycles; page field only.
// RULE19: write to app region keeps boot region readable; else halt cpu.
// RULE20: with interrupt enabled, level interrupt while command enable reads clear.
// RULE21: software should move vectors into boot region when using the interrupt.
// RULE22: software saves unchanged words before erasing for partial updates.
// RULE23: app busy flag reads one while app region is blocked. Boot-region operations assert app_region_blocked_o but leave the flag at zero.
// RULE24: writing read re-enable clears busy flag and reopens app region reads.
// RULE25: command enable self-clears on completion or missed four-cycle window.
module fsps_seq
  import fsps_pkg::*;
#(
  parameter int PAGE_WORDS_W = 5,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h1c00,
  parameter logic [15:0] BOOT_START_PAGE = 16'h00e0,
  parameter int OP_LEN = OP_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // core side
  input wire logic boot_reset_select_i,
  input wire logic store_program_instruction_i,
  input wire logic eeprom_write_i,
  input wire logic [15:0] lpm_addr_i,
  output logic [15:0] reset_vector_o,
  output logic [7:0] lpm_byte_o,
  output logic cpu_halt_o,
  output logic app_region_blocked_o,
  output logic prog_irq_o,
  // flash array side
  output logic flash_erase_o,
  output logic flash_write_o,
  output logic [15:0] flash_page_o,
  output logic [15:0] flash_wdata_o,
  output logic [PAGE_WORDS_W-1:0] flash_word_o,
  input wire logic [15:0] flash_rdata_i
);
  localparam int PW = PAGE_WORDS_W;
  localparam int OPW = $clog2(OP_LEN + 1);

  fsps_state_t state;
  logic [6:0] cmd;
  logic [2:0] win_cnt;
  logic [OPW-1:0] op_cnt;
  logic [PW:0] wr_idx;
  logic [7:0] pointer_low_byte;
  logic [7:0] pointer_high_byte;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  logic irq_en;
  logic app_region_busy_flag;
  logic is_write;
  logic [15:0] op_page;
  logic buf_clear;
  logic buf_load;
  logic [15:0] buf_rd;
  logic [15:0] ptr;
  logic [15:0] page_index_field;
  logic [PW-1:0] word_in_page_field;
  logic csr_wr;
  logic reen_wr;
  logic prog_go;
  logic op_done;

  assign ptr = {pointer_high_byte, pointer_low_byte}; // RULE3
  // page sits above the word field, byte select below it
  assign page_index_field = 16'(ptr >> (PW + 1)); // RULE4
  assign word_in_page_field = ptr[PW:1]; // RULE14
  assign csr_wr = reg_wr_i && (reg_addr_i == CSR_ADDR);
  assign reen_wr = csr_wr && reg_wdata_i[CSR_REEN_BIT] && reg_wdata_i[CSR_EN_BIT];
  assign prog_go = (state == FSPS_ARMED) && store_program_instruction_i;
  assign buf_load = prog_go && (cmd == CMD_LOAD) && !eeprom_write_i; // RULE13
  // a short op time must not cut a page write before its last word
  assign op_done = (state == FSPS_BUSY) && (op_cnt == OPW'(0)) && (wr_idx[PW] || !is_write);
  // eeprom write blocks arming and buffer loads, and wipes the loading in progress
  assign buf_clear = (reen_wr && state == FSPS_IDLE) || eeprom_write_i || // RULE17
    (op_done && is_write); // RULE15

  fsps_page_buf #(
    .WORDS(1 << PW),
    .AW(PW)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .clear_i(buf_clear),
    .load_i(buf_load),
    .load_addr_i(word_in_page_field),
    .load_data_i({data_hi, data_lo}),
    .rd_addr_i(wr_idx[PW-1:0]),
    .rd_data_o(buf_rd),
    .loaded_o()
  );

  // software-visible pointer, data pair and enable
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pointer_low_byte <= 8'h00;
      pointer_high_byte <= 8'h00;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
      irq_en <= 1'b0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        PTRL_ADDR: pointer_low_byte <= reg_wdata_i;
        PTRH_ADDR: pointer_high_byte <= reg_wdata_i;
        DATL_ADDR: data_lo <= reg_wdata_i;
        DATH_ADDR: data_hi <= reg_wdata_i;
        CFG_ADDR: irq_en <= reg_wdata_i[CFG_IE_BIT];
        default: ;
      endcase
    end
  end

  // command sequencer
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= FSPS_IDLE;
      cmd <= 7'h00;
      win_cnt <= 3'h0;
      op_cnt <= '0;
      is_write <= 1'b0;
      op_page <= 16'h0000;
      wr_idx <= '0;
    end else begin
      case (state)
        FSPS_IDLE: begin
          if (csr_wr && reg_wdata_i[CSR_EN_BIT] && !eeprom_write_i) begin
            cmd <= reg_wdata_i[6:0];
            win_cnt <= ARM_WINDOW;
            state <= FSPS_ARMED;
          end
        end
        FSPS_ARMED: begin
          if (prog_go && (cmd == CMD_ERASE || cmd == CMD_WRITE)) begin
            op_page <= page_index_field; // RULE5 RULE11 RULE18
            is_write <= (cmd == CMD_WRITE);
            op_cnt <= OPW'(OP_LEN - 1);
            wr_idx <= '0;
            state <= FSPS_BUSY;
          end else if (prog_go || win_cnt == 3'h1) begin
            // load and lock finish at once; unused window expires
            state <= FSPS_IDLE; // RULE6 RULE25
          end else begin
            win_cnt <= win_cnt - 3'h1;
          end
        end
        FSPS_BUSY: begin
          if (!wr_idx[PW]) begin
            wr_idx <= wr_idx + 1'b1;
          end
          if (op_done) begin
            state <= FSPS_IDLE; // RULE25
          end else if (op_cnt != OPW'(0)) begin
            op_cnt <= op_cnt - 1'b1;
          end
        end
        default: state <= FSPS_IDLE;
      endcase
    end
  end

  // busy flag clears only by reset or software re-enable, never alone
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      app_region_busy_flag <= 1'b0;
    end else if (state == FSPS_BUSY && op_page < BOOT_START_PAGE) begin
      app_region_busy_flag <= 1'b1; // RULE23
    end else if (reen_wr && state == FSPS_IDLE) begin
      app_region_busy_flag <= 1'b0; // RULE24
    end
  end

  // outputs toward core and flash array
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cpu_halt_o <= 1'b0;
      app_region_blocked_o <= 1'b0;
      prog_irq_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
      flash_page_o <= 16'h0000;
      flash_wdata_o <= 16'h0000;
      flash_word_o <= '0;
      reset_vector_o <= APP_RESET_ADDR;
    end else begin
      // strap is sampled by a clocked process, fuse has no write path
      reset_vector_o <= boot_reset_select_i ? APP_RESET_ADDR : BOOT_RESET_ADDR; // RULE1 RULE2
      cpu_halt_o <= (state == FSPS_BUSY) && (op_page >= BOOT_START_PAGE); // RULE12 RULE19
      app_region_blocked_o <= app_region_busy_flag || (state == FSPS_BUSY); // RULE24
      prog_irq_o <= irq_en && (state == FSPS_IDLE); // RULE20
      flash_erase_o <= (state == FSPS_BUSY) && !is_write && op_cnt == OPW'(OP_LEN - 1);
      flash_write_o <= (state == FSPS_BUSY) && is_write && !wr_idx[PW];
      flash_page_o <= op_page;
      flash_wdata_o <= buf_rd;
      flash_word_o <= wr_idx[PW-1:0];
    end
  end

  // load-program byte path
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lpm_byte_o <= 8'h00;
    end else begin
      lpm_byte_o <= lpm_addr_i[0] ? flash_rdata_i[15:8] : flash_rdata_i[7:0]; // RULE7
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CSR_ADDR: reg_rdata_o <= {irq_en, app_region_busy_flag, 2'b00,
          (state != FSPS_IDLE) && cmd[CSR_LOCK_BIT],
          (state != FSPS_IDLE) && cmd[CSR_WRITE_BIT],
          (state != FSPS_IDLE) && cmd[CSR_ERASE_BIT],
          state != FSPS_IDLE};
        PTRL_ADDR: reg_rdata_o <= pointer_low_byte;
        PTRH_ADDR: reg_rdata_o <= pointer_high_byte;
        DATL_ADDR: reg_rdata_o <= data_lo;
        DATH_ADDR: reg_rdata_o <= data_hi;
        CFG_ADDR: reg_rdata_o <= {7'h00, irq_en};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule : fsps_seq

// *** fsps_seq_props.sv ***
`timescale 1ns/1ns
module fsps_seq_chk
  import fsps_pkg::*;
#(
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h1c00,
  parameter logic [15:0] BOOT_START_PAGE = 16'h00e0
) (
  // inputs
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic boot_reset_select_i,
  input wire logic [15:0] lpm_addr_i,
  input wire logic [15:0] flash_rdata_i,
  // outputs
  input wire logic [15:0] reset_vector_o,
  input wire logic [7:0] lpm_byte_o,
  input wire logic cpu_halt_o,
  input wire logic prog_irq_o,
  input wire logic flash_erase_o,
  input wire logic flash_write_o,
  input wire logic [15:0] flash_page_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  chk_vec_app: assert property ($past(!srst_i) && boot_reset_select_i &&
    $past(boot_reset_select_i) |-> reset_vector_o == 16'h0000) else $error("bad app vector");
  chk_vec_boot: assert property ($past(!srst_i) && !boot_reset_select_i &&
    !$past(boot_reset_select_i) |-> reset_vector_o == BOOT_RESET_ADDR) else $error("bad boot vector");
  chk_erase_pulse: assert property (flash_erase_o |=> !flash_erase_o)
    else $error("erase pulse too long");
  chk_op_excl: assert property (!(flash_erase_o && flash_write_o))
    else $error("erase and write together");
  chk_irq_erase: assert property (prog_irq_o |-> !flash_erase_o)
    else $error("interrupt during erase");
  chk_halt_page: assert property (cpu_halt_o |-> flash_page_o >= BOOT_START_PAGE)
    else $error("halt on app page");
  chk_erase_app: assert property (flash_erase_o && flash_page_o < BOOT_START_PAGE
    |-> !cpu_halt_o) else $error("halt on app erase");
  chk_lpm_byte: assert property ($past(!srst_i) |-> lpm_byte_o == ($past(lpm_addr_i[0]) ?
    $past(flash_rdata_i[15:8]) : $past(flash_rdata_i[7:0]))) else $error("wrong byte");
  chk_page_hold: assert property (flash_write_o && $past(flash_write_o)
    |-> $stable(flash_page_o)) else $error("page moved in write");
endmodule : fsps_seq_chk

bind fsps_seq fsps_seq_chk #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR),
  .BOOT_START_PAGE(BOOT_START_PAGE)) u_fsps_seq_chk (.sys_clk_i(sys_clk_i),
  .srst_i(srst_i), .boot_reset_select_i(boot_reset_select_i), .lpm_addr_i(lpm_addr_i),
  .flash_rdata_i(flash_rdata_i), .reset_vector_o(reset_vector_o), .lpm_byte_o(lpm_byte_o),
  .cpu_halt_o(cpu_halt_o), .prog_irq_o(prog_irq_o), .flash_erase_o(flash_erase_o),
  .flash_write_o(flash_write_o), .flash_page_o(flash_page_o));

// *** fsps_flash_model.sv ***
`timescale 1ns/1ns
module fsps_flash_model (
  // lookup
  input wire logic [15:0] addr_i,
  // data
  output logic [15:0] rdata_o
);
  // the two bytes differ, so a swapped byte select shows up
  assign rdata_o = {~addr_i[8:1], addr_i[8:1]};
endmodule : fsps_flash_model

// *** flash_self_programming_sequencer_test.sv ***
`timescale 1ns/1ns
module flash_self_programming_sequencer_test;
  import fsps_pkg::*;
  typedef struct packed {logic [15:0] a; logic [7:0] e;} fsps_row_t;
  localparam logic [15:0] BOOT_VEC = 16'h1c00;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic boot_reset_select_i = 1'b1;
  logic prog_i = 1'b0;
  logic eeprom_write_i = 1'b0;
  logic [15:0] lpm_addr_i = 16'h0000;
  logic [7:0] reg_rdata_o, lpm_byte_o, d;
  logic [15:0] reset_vector_o, flash_page_o, flash_wdata_o, flash_rdata_i;
  logic cpu_halt_o, app_region_blocked_o, prog_irq_o, flash_erase_o, flash_write_o;
  logic [4:0] flash_word_o;
  int miscompares = 0;
  int num_checks = 0;
  fsps_row_t rows [4] = '{'{16'h0010, 8'h08}, '{16'h0011, 8'hf7}, '{16'h01fe, 8'hff},
    '{16'h01ff, 8'h00}};

  fsps_seq #(.OP_LEN(8), .BOOT_RESET_ADDR(BOOT_VEC)) u_fsps_seq (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .boot_reset_select_i(boot_reset_select_i),
    .store_program_instruction_i(prog_i), .eeprom_write_i(eeprom_write_i),
    .lpm_addr_i(lpm_addr_i), .reset_vector_o(reset_vector_o), .lpm_byte_o(lpm_byte_o),
    .cpu_halt_o(cpu_halt_o), .app_region_blocked_o(app_region_blocked_o),
    .prog_irq_o(prog_irq_o), .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
    .flash_page_o(flash_page_o), .flash_wdata_o(flash_wdata_o), .flash_word_o(flash_word_o),
    .flash_rdata_i(flash_rdata_i));
  fsps_flash_model u_fsps_flash_model (.addr_i(lpm_addr_i), .rdata_o(flash_rdata_i));

  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // the store-program pulse lands one edge after the control write
  task automatic arm(input logic [7:0] cmd);
    wr(CSR_ADDR, cmd);
    prog_i <= 1'b1;
    @(posedge sys_clk_i);
    prog_i <= 1'b0;
  endtask : arm

  task automatic wait_idle;
    for (int i = 0; i < 60; i++) begin
      rd(CSR_ADDR);
      if (d[CSR_EN_BIT] === 1'b0) return;
    end
    miscompares++;
    end_sim();
  endtask : wait_idle

  task automatic wait_op(input bit wr_op, input logic [4:0] w);
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (!wr_op && flash_erase_o === 1'b1) return;
      if (wr_op && flash_write_o === 1'b1 && flash_word_o === w) return;
    end
    miscompares++;
    end_sim();
  endtask : wait_op

  task automatic ld(input logic [7:0] pl, input logic [15:0] v);
    wr(PTRL_ADDR, pl);
    wr(DATL_ADDR, v[7:0]);
    wr(DATH_ADDR, v[15:8]);
    arm({1'b0, CMD_LOAD});
    wait_idle();
  endtask : ld

  initial begin
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk("vector", reset_vector_o, 16'h0000);
    foreach (rows[k]) begin
      @(posedge sys_clk_i);
      lpm_addr_i <= rows[k].a;
      repeat (2) @(posedge sys_clk_i);
      #1 chk("lpm", 16'(lpm_byte_o), 16'(rows[k].e));
    end
    wr(CFG_ADDR, 8'h01);
    wr(PTRL_ADDR, 8'h34);
    wr(PTRH_ADDR, 8'h12);
    arm({1'b0, CMD_ERASE});
    wait_op(1'b0, 5'h00);
    chk("erase_page", flash_page_o, 16'h0048);
    chk("erase_halt", 16'(cpu_halt_o), 16'h0000);
    chk("irq_busy", 16'(prog_irq_o), 16'h0000);
    wr(PTRH_ADDR, 8'h00);
    #1 chk("latched", flash_page_o, 16'h0048);
    chk("blocked", 16'(app_region_blocked_o), 16'h0001);
    wait_idle();
    #1 chk("irq", 16'(prog_irq_o), 16'h0001);
    chk("busy", 16'(d[CSR_BUSY_BIT]), 16'h0001);
    wr(CSR_ADDR, 8'h11);
    rd(CSR_ADDR);
    chk("busy_clr", 16'(d[CSR_BUSY_BIT]), 16'h0000);
    chk("unblocked", 16'(app_region_blocked_o), 16'h0000);
    // the re-enable write arms too, so let its window run out first
    repeat (4) @(posedge sys_clk_i);
    wr(CSR_ADDR, 8'h01);
    rd(CSR_ADDR);
    chk("armed", 16'(d[CSR_EN_BIT]), 16'h0001);
    repeat (8) @(posedge sys_clk_i);
    rd(CSR_ADDR);
    chk("window", 16'(d[CSR_EN_BIT]), 16'h0000);
    wr(PTRH_ADDR, 8'h38);
    ld(8'h46, 16'h1122);
    ld(8'h42, 16'h3344);
    for (int p = 0; p < 3; p++) begin
      if (p == 2) begin
        ld(8'h46, 16'h5566);
        @(posedge sys_clk_i);
        eeprom_write_i <= 1'b1;
        @(posedge sys_clk_i);
        eeprom_write_i <= 1'b0;
      end
      wr(PTRL_ADDR, 8'h40);
      arm({1'b0, CMD_ERASE});
      wait_idle();
      arm({1'b0, CMD_WRITE});
      if (p == 0) begin
        wait_op(1'b1, 5'h01);
        chk("word1", flash_wdata_o, 16'h3344);
        chk("halt", 16'(cpu_halt_o), 16'h0001);
      end
      wait_op(1'b1, 5'h03);
      chk("word3", flash_wdata_o, (p == 0) ? 16'h1122 : 16'hffff);
      chk("page", flash_page_o, 16'h00e1);
      wait_idle();
    end
    ld(8'h46, 16'h7788);
    @(posedge sys_clk_i);
    srst_i <= 1'b1;
    boot_reset_select_i <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 chk("boot_vector", reset_vector_o, BOOT_VEC);
    wr(PTRH_ADDR, 8'h38);
    wr(PTRL_ADDR, 8'h40);
    arm({1'b0, CMD_ERASE});
    wait_idle();
    arm({1'b0, CMD_WRITE});
    wait_op(1'b1, 5'h03);
    chk("reset_clr", flash_wdata_o, 16'hffff);
    end_sim();
  end
endmodule : flash_self_programming_sequencer_test
